// ==== remainder_out_chk.sv ====
// remainder_out_chk: timing checks on the word feed between both ends
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module remainder_out_chk
    import remainder_out_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // feed
    input wire logic [31:0] word_data,
    input wire logic word_qualifier,
    input wire logic preload_strobe,
    input wire logic [31:0] preload_value,
    input wire logic finalize_strobe,
    input wire logic check_strobe,
    // answers
    input wire logic [31:0] remainder_out,
    input wire logic residue_ok
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////
    sequence s_fin; finalize_strobe ##1 !(word_qualifier || preload_strobe); endsequence
    property p_pre; preload_strobe |=> remainder_out == $past(preload_value); endproperty
    a_pre: assert property (p_pre) else $error("preload lost");
    property p_hold; !(word_qualifier || preload_strobe || $past(finalize_strobe)) |=> $stable(remainder_out); endproperty
    a_hold: assert property (p_hold) else $error("idle change");
    // the inversion is shown once; the stored remainder stays true
    property p_fin; s_fin |=> remainder_out == ~$past(remainder_out); endproperty
    a_fin: assert property (p_fin) else $error("no inversion");
    property p_chk; check_strobe && word_qualifier && !preload_strobe && !finalize_strobe
        |=> residue_ok == (remainder_out == CRC_RESIDUE); endproperty
    a_chk: assert property (p_chk) else $error("bad match");
    property p_okc; residue_ok |-> $past(check_strobe) && !$past(preload_strobe); endproperty
    a_okc: assert property (p_okc) else $error("stray match");
    property p_fw; finalize_strobe || check_strobe |-> word_qualifier; endproperty
    a_fw: assert property (p_fw) else $error("strobe alone");
    property p_f1; finalize_strobe |=> !finalize_strobe; endproperty
    a_f1: assert property (p_f1) else $error("long finalize");
    property p_rst; disable iff (1'b0) !nrst_i |=> remainder_out == REM_RESET && !residue_ok; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
endmodule // remainder_out_chk

// ==== remainder_out_device.sv ====
// remainder_out_device: remainder generator and residue verifier for one word stream
// assumes the feeder keeps packet order and seeds each packet before use
`timescale 1ns/1ps
//
// Contract
// - fold qualified word; ignore unqualified words
// - feeder presents next word in order
// - finalize drives inverted remainder out
// - finalize comes with last payload word
// - preload loads remainder from preload value
// - feeder preloads saved partial remainder
// - reset clears remainder and match outputs
// - remainder output tracks current remainder
// - feeder saves and restores interleaved remainders
// - check compares remainder against residue
// - feeder checks together with trailer word
// - match only when remainder equals residue
// - all inputs sampled on one clock
// - feeder seeds all ones before packet
// - words may follow the preload pulse
// - finalize lasts exactly one cycle
// - match pulse lasts one cycle
module remainder_out_device
    import remainder_out_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // word feed
    remainder_out_if.device link,
    // user side
    output logic [31:0] remainder_o,
    output logic residue_ok_o
);
    typedef struct packed {
        logic [31:0] rem;
        logic [31:0] out;
        logic ok;
    } state_t;

    // rem is the true remainder; out is what the user sees
    // ok is the one-cycle match pulse
    state_t state_reg;
    state_t state_next;

    // no framing here: the feeder owns packet boundaries and order

    ////////////////////////////////////////////////////////////////
    // request decode
    logic take_preload;
    logic take_word;
    logic invert_now;
    logic check_now;

    always_comb begin
        // defaults first so every path assigns every flag
        take_preload = 1'b0;
        take_word = 1'b0;
        invert_now = 1'b0;
        check_now = 1'b0;

        if (link.preload_strobe) begin
            // preload wins; a word, finalize or check beside it is void
            take_preload = 1'b1;
        end else begin
            take_word = link.word_qualifier;
            invert_now = link.finalize_strobe;
            check_now = link.check_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////
    // fold chain: one shift stage per data bit, msb first
    // fully parallel so a word folds per clock; depth is the price
    wire logic [31:0] fold_chain [0:WORD_W];
    // stage k folds data bit WORD_W - 1 - k

    assign fold_chain[0] = state_reg.rem;

    for (genvar k = 0; k < WORD_W; k++) begin : g_fold
        logic feedback;

        // top remainder bit against the data bit of this stage
        assign feedback = fold_chain[k][31] ^ link.word_data[WORD_W - 1 - k];

        for (genvar j = 0; j < WORD_W; j++) begin : g_tap
            logic carry_in;
            logic tap_bit;

            // bit zero shifts in a zero
            if (j == 0) begin : g_lsb
                assign carry_in = 1'b0;
            end else begin : g_upper
                assign carry_in = fold_chain[k][j - 1];
            end

            // a tap wherever the polynomial holds a one
            assign tap_bit = feedback && CRC_POLY[j];

            // shifted bit plus tap
            assign fold_chain[k + 1][j] = carry_in ^ tap_bit;
        end
    end

    ////////////////////////////////////////////////////////////////
    // next remainder, chosen bit by bit
    wire logic [31:0] rem_after;

    // preload overrides the fold, so a resumed packet never mixes
    for (genvar b = 0; b < WORD_W; b++) begin : g_next
        logic nxt;

        always_comb begin
            if (take_preload) begin
                nxt = link.preload_value[b];
            end else if (take_word) begin
                nxt = fold_chain[WORD_W][b];
            end else begin
                // hold when nothing is offered
                nxt = state_reg.rem[b];
            end
        end

        assign rem_after[b] = nxt;
    end

    ////////////////////////////////////////////////////////////////
    // generator view: inverted for the finalize cycle only
    // the stored remainder is never inverted, so a packet can resume
    wire logic [31:0] shown_rem;

    for (genvar b = 0; b < WORD_W; b++) begin : g_show
        logic bit_view;

        // inverted view lasts one cycle only
        always_comb begin
            if (invert_now) begin
                bit_view = ~rem_after[b];
            end else begin
                bit_view = rem_after[b];
            end
        end

        assign shown_rem[b] = bit_view;
    end

    ////////////////////////////////////////////////////////////////
    // verifier: residue compare bit by bit, then reduced
    // check sees the remainder after the trailer word of this edge
    wire logic [31:0] hit_bits;
    logic residue_hit;

    for (genvar b = 0; b < WORD_W; b++) begin : g_hit
        logic same;

        always_comb begin
            if (rem_after[b] == CRC_RESIDUE[b]) begin
                same = 1'b1;
            end else begin
                same = 1'b0;
            end
        end

        assign hit_bits[b] = same;
    end

    // a wrong trailer leaves some other value; no partial credit
    assign residue_hit = &hit_bits;

    ////////////////////////////////////////////////////////////////
    // state update
    // one struct, one register stage; all outputs come from it
    always_comb begin
        state_next = state_reg;
        state_next.rem = rem_after;
        state_next.out = shown_rem;

        // match stands one cycle, then falls unless checked again
        if (check_now) begin
            state_next.ok = residue_hit;
        end else begin
            state_next.ok = 1'b0;
        end
    end

    // synchronous reset: outputs read zero from the edge after it
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state_reg <= '{rem: REM_RESET, out: REM_RESET, ok: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // link side
    assign link.remainder_out = state_reg.out;
    assign link.residue_ok = state_reg.ok;

    // user side
    assign remainder_o = state_reg.out;
    assign residue_ok_o = state_reg.ok;
endmodule // remainder_out_device

// ==== remainder_out_feeder.sv ====
// remainder_out_feeder: reassembly-side end that seeds, feeds, finalizes and checks
// assumes user requests are one-cycle pulses; one request per cycle
`timescale 1ns/1ps
module remainder_out_feeder
    import remainder_out_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // word feed
    remainder_out_if.feeder link,
    // user requests
    input wire logic start_i,
    input wire logic resume_i,
    input wire logic [31:0] saved_rem_i,
    input wire logic word_valid_i,
    input wire logic [31:0] word_i,
    input wire logic last_i,
    input wire logic trailer_i,
    // user results
    output logic [31:0] remainder_o,
    output logic residue_ok_o
);
    typedef struct packed {
        logic [31:0] data;
        logic qual;
        logic pre;
        logic [31:0] pre_val;
        logic fin;
        logic chk;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = '{default: '0};
        state_next.data = state_reg.data;
        state_next.pre_val = state_reg.pre_val;
        if (start_i) begin
            state_next.pre = 1'b1;
            state_next.pre_val = CRC_SEED;
        end else if (resume_i) begin
            state_next.pre = 1'b1;
            state_next.pre_val = saved_rem_i;
        end else if (word_valid_i) begin
            // words only after the preload cycle, never with it
            state_next.qual = 1'b1;
            state_next.data = word_i;
            state_next.fin = last_i;
            state_next.chk = trailer_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state_reg <= '{default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign link.word_data = state_reg.data;
    assign link.word_qualifier = state_reg.qual;
    assign link.preload_strobe = state_reg.pre;
    assign link.preload_value = state_reg.pre_val;
    assign link.finalize_strobe = state_reg.fin;
    assign link.check_strobe = state_reg.chk;
    assign remainder_o = link.remainder_out;
    assign residue_ok_o = link.residue_ok;
endmodule // remainder_out_feeder

// ==== remainder_out_if.sv ====
// remainder_out_if: word feed between reassembly logic and both remainder ends
// assumes one clock; the feeder drives, the devices answer
`timescale 1ns/1ps
interface remainder_out_if;
    logic [31:0] word_data;
    logic word_qualifier;
    logic preload_strobe;
    logic [31:0] preload_value;
    logic finalize_strobe;
    logic check_strobe;
    logic [31:0] remainder_out;
    logic residue_ok;

    modport device (
        input word_data, word_qualifier, preload_strobe, preload_value,
        input finalize_strobe, check_strobe,
        output remainder_out, residue_ok
    );
    modport feeder (
        output word_data, word_qualifier, preload_strobe, preload_value,
        output finalize_strobe, check_strobe,
        input remainder_out, residue_ok
    );
endinterface

// ==== remainder_out_pkg.sv ====
// remainder_out_pkg: constants shared by the remainder generator and verifier ends
// assumes a single 20 MHz clock domain and synchronous active-low reset
package remainder_out_pkg;
    localparam int unsigned WORD_W = 32;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_RESIDUE = 32'hC704DD7B;
    localparam logic [31:0] REM_RESET = 32'h00000000;
    localparam int unsigned CLK_PERIOD_NS = 50;

    // fold one 32-bit word msb first into a remainder
    function automatic logic [31:0] crc_fold(input logic [31:0] rem_in, input logic [31:0] word);
        logic [31:0] r;
        r = rem_in;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            if (r[31] ^ word[i]) begin
                r = {r[30:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction
endpackage

// ==== testbench.sv ====
// testbench: feeder and device joined, checked against an integer model
// assumes results appear two cycles after each user request
`timescale 1ns/1ps
module testbench;
    import remainder_out_pkg::*;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic start_i = 1'b0, resume_i = 1'b0, word_valid_i = 1'b0, last_i = 1'b0, trailer_i = 1'b0;
    logic [31:0] saved_rem_i = '0, word_i = '0, f_rem, d_rem;
    logic f_ok, d_ok;
    logic [32:0] cur = '0, d1 = '0, d2 = '0;
    int num_errors = 0, total_checks = 0, cyc = 0;
    int unsigned m = 0, sv = 0, tr;
    int unsigned w[4];
    remainder_out_if link ();
    remainder_out_feeder i_remainder_out_feeder (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .link(link), .start_i(start_i),
        .resume_i(resume_i), .saved_rem_i(saved_rem_i), .word_valid_i(word_valid_i), .word_i(word_i),
        .last_i(last_i), .trailer_i(trailer_i), .remainder_o(f_rem), .residue_ok_o(f_ok));
    remainder_out_device i_remainder_out_device (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .link(link), .remainder_o(d_rem),
        .residue_ok_o(d_ok));
    remainder_out_chk i_remainder_out_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .word_data(link.word_data),
        .word_qualifier(link.word_qualifier), .preload_strobe(link.preload_strobe),
        .preload_value(link.preload_value), .finalize_strobe(link.finalize_strobe),
        .check_strobe(link.check_strobe), .remainder_out(link.remainder_out), .residue_ok(link.residue_ok));
    always #25 core_clk_i = ~core_clk_i;
    ////////////////////////////////
    // own msb-first fold, kept apart from the design's
    function automatic int unsigned fold(int unsigned r, int unsigned x);
        for (int i = 31; i >= 0; i--) r = ((r >> 31) ^ ((x >> i) & 1)) ? (r << 1) ^ CRC_POLY : r << 1;
        return r;
    endfunction
    task automatic op(input bit s, r, v, l, t, input int unsigned x);
        @(posedge core_clk_i);
        start_i <= s; resume_i <= r; saved_rem_i <= sv; word_valid_i <= v; word_i <= x; last_i <= l; trailer_i <= t;
        if (s) m = CRC_SEED; else if (r) m = sv; else if (v) m = fold(m, x);
        cur <= {t && v && !s && !r && m == CRC_RESIDUE, (l && v && !s && !r) ? ~m : m};
    endtask
    task automatic chk_rem(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin num_errors++; $display("[ERR] %0t remainder %h exp %h", $time, got, exp); end
    endtask
    task automatic chk_ok(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin num_errors++; $display("[ERR] %0t match %b exp %b", $time, got, exp); end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////
    // a hang counts as a mismatch
    always @(posedge core_clk_i) begin
        d1 <= cur; d2 <= d1; cyc <= cyc + 1;
        if (cyc == 3000) begin num_errors++; tally_and_finish(); end
    end
    always @(negedge core_clk_i) if (nrst_i) begin
        chk_rem(d_rem, d2[31:0]);
        chk_rem(f_rem, d2[31:0]);
        chk_ok(d_ok, d2[32]);
    end
    initial begin
        void'($urandom(32'h5744b248));
        repeat (20) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        for (int n = 1; n <= 4; n++) begin
            op(1, 0, 0, 0, 0, 0);
            for (int i = 0; i < n; i++) begin w[i] = $urandom; op(0, 0, 1, i == n - 1, 0, w[i]); end
            tr = ~m;
            op(0, 0, 0, 0, 0, 0);
            op(1, 0, 0, 0, 0, 0);
            for (int i = 0; i < n; i++) op(0, 0, 1, 0, 0, w[i]);
            op(0, 0, 1, 0, 1, tr ^ (n == 3));
        end
        // interleave two packets; preload wins over a word on the same cycle
        op(1, 0, 0, 0, 0, 0);
        op(0, 0, 1, 0, 0, $urandom);
        sv = m;
        op(1, 0, 1, 0, 0, $urandom);
        op(0, 0, 1, 0, 0, $urandom);
        op(0, 1, 0, 0, 0, 0);
        op(0, 0, 1, 1, 0, $urandom);
        repeat (4) op(0, 0, 0, 0, 0, 0);
        tally_and_finish();
    end
endmodule // testbench
